//--- design/dcc_clk_div.sv
// Purpose: Integer divider for the clock-output pin, producing a divided clock level
// Assumes: Divide ratio of at least two (one or zero holds the output low), changes take effect in the next cycle
// Notes: Output is a registered level, high for half the ratio rounded down in every period of ratio cycles
`timescale 1ns/100ps
module dcc_clk_div
   import dcc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic [7:0] ratio_i,
   input wire logic enable_i,
   // Output
   output logic clk_o
);
   typedef struct packed {
      logic [7:0] cnt;
      logic out;
   } dcc_div_state_type;

   dcc_div_state_type st_q, st_d;

   // Count master clocks, high for the first half of each period
   always_comb begin
      st_d = st_q;
      if (!enable_i || ratio_i <= 8'h01) begin
         st_d.cnt = 8'h00;
         st_d.out = 1'b0;
      end else begin
         if (st_q.cnt >= ratio_i - 8'h01) begin
            st_d.cnt = 8'h00;
         end else begin
            st_d.cnt = st_q.cnt + 8'h01;
         end
         st_d.out = (st_d.cnt < (ratio_i >> 1));
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign clk_o = st_q.out;
endmodule // dcc_clk_div

//--- design/dcc_pkg.sv
// Purpose: Shared constants for the converter channel and clock-output configuration block
// Assumes: Avalon-MM slave with 32-bit data, registers one word each, 8-bit data in low bits
// Notes: Offsets are byte addresses; index times four
package dcc_pkg;
   // Register indices and byte addresses
   localparam logic [3:0] IDX_CLK_CTRL_ZERO = 4'h0;
   localparam logic [3:0] IDX_CLK_CTRL_ONE = 4'h1;
   localparam logic [3:0] IDX_CONV_CTRL_FIRST = 4'h2;
   localparam logic [3:0] IDX_POWER_BASE = 4'h3;
   localparam logic [3:0] IDX_ATTEN_BASE = 4'h8;
   localparam logic [7:0] ADDR_CLK_CTRL_ZERO = 8'h00;
   localparam logic [7:0] ADDR_CLK_CTRL_ONE = 8'h04;
   localparam logic [7:0] ADDR_CONV_CTRL_FIRST = 8'h08;
   localparam logic [7:0] ADDR_POWER_BASE = 8'h0c;
   localparam logic [7:0] ADDR_ATTEN_BASE = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h50;
   localparam logic [7:0] ADDR_CLK_DIV = 8'h54;
   localparam int NUM_CHAN = 12;
   localparam int NUM_POWER_REGS = 3;
   // Field positions
   localparam int FS_LSB = 1;
   localparam int CLKOUT_SEL_LSB = 4;
   localparam int GLOBAL_PWR_LSB = 6;
   localparam int CM_OFF_BIT = 0;
   localparam int TDM_BIT = 3;
   // Reset values
   localparam logic [7:0] RST_CLK_CTRL_ZERO = 8'h00;
   localparam logic [7:0] RST_CLK_CTRL_ONE = 8'h20;
   localparam logic [7:0] RST_CONV_CTRL_FIRST = 8'h00;
   localparam logic [7:0] RST_POWER = 8'h00;
   localparam logic [7:0] RST_ATTEN = 8'h00;
   // Band codes
   localparam logic [1:0] FS_BAND_48 = 2'h0;
   localparam logic [1:0] FS_BAND_96 = 2'h1;
   localparam logic [1:0] FS_BAND_192 = 2'h2;
   localparam logic [1:0] FS_BAND_192_LL = 2'h3;
   // Oversampling ratios per band
   localparam logic [8:0] OSR_48 = 9'h100;
   localparam logic [8:0] OSR_96 = 9'h080;
   localparam logic [8:0] OSR_192 = 9'h040;
   // Clock-output select codes
   localparam logic [1:0] CLKOUT_LOW_BAND = 2'h0;
   localparam logic [1:0] CLKOUT_HIGH_BAND = 2'h1;
   localparam logic [1:0] CLKOUT_BUFFERED = 2'h2;
   localparam logic [1:0] CLKOUT_OFF = 2'h3;
   // Power levels
   localparam logic [1:0] PWR_BEST = 2'h0;
   localparam logic [1:0] PWR_GOOD = 2'h1;
   localparam logic [1:0] PWR_LOWER = 2'h2;
   localparam logic [1:0] PWR_LOWEST = 2'h3;
   // Attenuation step in millidecibel
   localparam int ATTEN_STEP_MDB = 375;
   // Output windows in kHz for the low-jitter settings
   localparam int LOW_BAND_MIN_KHZ = 4000;
   localparam int LOW_BAND_MAX_KHZ = 6000;
   localparam int HIGH_BAND_MIN_KHZ = 8000;
   localparam int HIGH_BAND_MAX_KHZ = 12000;
   localparam logic [7:0] DIV_MAX = 8'h0c;
   // Operating mode
   typedef enum logic [1:0] {
      MODE_RESET = 2'b00,
      MODE_PROGRAM = 2'b01,
      MODE_STANDALONE = 2'b11
   } dcc_mode_type;
endpackage : dcc_pkg

//--- design/dcc_top.sv
// Purpose: Channel, filter band, power level and clock-output configuration of a 12-channel DAC
// Assumes: sys_clk_i stands for the master clock input; Avalon-MM slave with waitrequest
// Notes: Analog paths are represented by the configuration outputs they would steer
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
module dcc_top
   import dcc_pkg::*;
#(
   parameter int MCLK_KHZ = 12288
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   // Mode strap
   input wire logic standalone_select_i,
   input wire logic standalone_slave_i,
   input wire logic standalone_tdm_i,
   // Serial clock pins, two-way
   input wire logic frame_clock_pin_i,
   output logic frame_clock_pin_o,
   output logic frame_clock_pin_oe_o,
   input wire logic bit_clock_pin_i,
   output logic bit_clock_pin_o,
   output logic bit_clock_pin_oe_o,
   // Clock output pin
   output logic clock_output_pin_o,
   // Converter configuration
   output logic [8:0] osr_o,
   output logic low_latency_o,
   output logic [2:0] mclk_ratio_shift_o,
   output logic tdm_mode_o,
   output logic [3:0] data_lines_used_o,
   output logic [NUM_CHAN*8-1:0] atten_o,
   output logic [NUM_CHAN*2-1:0] power_level_o,
   output logic common_mode_ref_en_o
);
   typedef struct packed {
      dcc_mode_type mode;
      logic [7:0] clk_ctrl_zero;
      logic [7:0] clk_ctrl_one;
      logic [7:0] conv_ctrl;
      logic [NUM_POWER_REGS*8-1:0] power;
      logic [NUM_CHAN*8-1:0] atten;
      logic ack;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [8:0] osr;
      logic [NUM_CHAN*2-1:0] plevel;
      logic [7:0] div;
      logic fclk;
      logic bclk;
   } dcc_state_type;

   dcc_state_type st_q, st_d;
   logic req;
   logic [5:0] word_idx;
   logic [7:0] wbyte;
   logic [1:0] band;
   logic [1:0] glob_pwr;
   logic [1:0] clk_sel;
   logic [7:0] div_ratio;
   logic div_clk;
   logic [NUM_CHAN*2-1:0] plevel_d;

   assign req = avs_read_i | avs_write_i;
   assign word_idx = avs_address_i[7:2];
   assign wbyte = avs_writedata_i[7:0];
   assign band = st_q.conv_ctrl[FS_LSB +: 2];
   assign glob_pwr = st_q.clk_ctrl_one[GLOBAL_PWR_LSB +: 2];
   assign clk_sel = st_q.clk_ctrl_one[CLKOUT_SEL_LSB +: 2];

   // Divide ratio picks the smallest integer landing below the window top
   function automatic logic [7:0] pick_div(input int max_khz);
      logic [7:0] r;
      r = DIV_MAX;
      for (int k = int'(DIV_MAX); k >= 1; k--) begin
         if ((MCLK_KHZ + k - 1) / k <= max_khz) begin
            r = 8'(k);
         end
      end
      return r;
   endfunction

   // Integer division for the low-jitter clock-output settings
   always_comb begin
      div_ratio = 8'h01;
      case (clk_sel)
         CLKOUT_LOW_BAND: div_ratio = pick_div(LOW_BAND_MAX_KHZ);
         CLKOUT_HIGH_BAND: div_ratio = pick_div(HIGH_BAND_MAX_KHZ);
         default: div_ratio = 8'h01;
      endcase
   end

   // Per-channel power level with the global override
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++) begin : g_pwr
         // Four channels share one power register, two bits each at 7:6, 5:4, 3:2, 1:0
         localparam int REG = ch / 4;
         localparam int POS = 6 - 2 * (ch % 4);
         // Global level wins whenever it is not the best-performance code
         assign plevel_d[ch*2 +: 2] = (glob_pwr != PWR_BEST) ? glob_pwr
                                      : st_q.power[REG*8 + POS +: 2];
      end
   endgenerate

   // Register file, mode capture and derived configuration
   always_comb begin
      st_d = st_q;
      st_d.ack = 1'b0;
      st_d.plevel = plevel_d;
      // Mode chosen once at the first clock after reset release
      if (st_q.mode == MODE_RESET) begin
         if (standalone_select_i) begin
            st_d.mode = MODE_STANDALONE;
            st_d.conv_ctrl[TDM_BIT] = standalone_tdm_i;
         end else begin
            st_d.mode = MODE_PROGRAM;
         end
      end
      // Oversampling ratio by band
      case (band)
         FS_BAND_48: st_d.osr = OSR_48;
         FS_BAND_96: st_d.osr = OSR_96;
         default: st_d.osr = OSR_192;
      endcase
      // Serial clocks generated continuously; driven onto the pins only when standalone master
      st_d.div = st_q.div + 8'h01;
      st_d.bclk = st_q.div[1];
      st_d.fclk = st_q.div[7];
      // Bus access answered one cycle after the request
      if (req && !st_q.ack) begin
         st_d.ack = 1'b1;
         st_d.resp = 2'h0;
         st_d.rdata = 32'h0;
         case (avs_address_i)
            ADDR_CLK_CTRL_ZERO: st_d.rdata = {24'h0, st_q.clk_ctrl_zero};
            ADDR_CLK_CTRL_ONE: st_d.rdata = {24'h0, st_q.clk_ctrl_one};
            ADDR_CONV_CTRL_FIRST: st_d.rdata = {24'h0, st_q.conv_ctrl};
            ADDR_STATUS: st_d.rdata = {21'h0, st_q.osr, st_q.mode};
            ADDR_CLK_DIV: st_d.rdata = {24'h0, div_ratio};
            default: begin
               if (word_idx >= 6'(IDX_POWER_BASE)
                   && word_idx < 6'(IDX_POWER_BASE) + 6'(NUM_POWER_REGS)) begin
                  st_d.rdata = {24'h0, st_q.power[(word_idx - 6'(IDX_POWER_BASE)) * 8 +: 8]};
               end else if (word_idx >= 6'(IDX_ATTEN_BASE)
                            && word_idx < 6'(IDX_ATTEN_BASE) + 6'(NUM_CHAN)) begin
                  st_d.rdata = {24'h0, st_q.atten[(word_idx - 6'(IDX_ATTEN_BASE)) * 8 +: 8]};
               end else begin
                  st_d.resp = 2'h2;
               end
            end
         endcase
         if (avs_write_i && avs_byteenable_i[0] && st_q.mode == MODE_PROGRAM) begin
            case (avs_address_i)
               ADDR_CLK_CTRL_ZERO: st_d.clk_ctrl_zero = wbyte;
               ADDR_CLK_CTRL_ONE: st_d.clk_ctrl_one = wbyte;
               ADDR_CONV_CTRL_FIRST: st_d.conv_ctrl = wbyte;
               default: begin
                  if (word_idx >= 6'(IDX_POWER_BASE)
                      && word_idx < 6'(IDX_POWER_BASE) + 6'(NUM_POWER_REGS)) begin
                     st_d.power[(word_idx - 6'(IDX_POWER_BASE)) * 8 +: 8] = wbyte;
                  end else if (word_idx >= 6'(IDX_ATTEN_BASE)
                               && word_idx < 6'(IDX_ATTEN_BASE) + 6'(NUM_CHAN)) begin
                     st_d.atten[(word_idx - 6'(IDX_ATTEN_BASE)) * 8 +: 8] = wbyte;
                  end
               end
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
         st_q.mode <= MODE_RESET;
         st_q.clk_ctrl_zero <= RST_CLK_CTRL_ZERO;
         st_q.clk_ctrl_one <= RST_CLK_CTRL_ONE;
         st_q.conv_ctrl <= RST_CONV_CTRL_FIRST;
         st_q.power <= {NUM_POWER_REGS{RST_POWER}};
         st_q.atten <= {NUM_CHAN{RST_ATTEN}};
         st_q.osr <= OSR_48;
      end else begin
         st_q <= st_d;
      end
   end

   // Divider for the low-jitter clock output
   dcc_clk_div u_div (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .ratio_i(div_ratio),
      .enable_i(clk_sel == CLKOUT_LOW_BAND || clk_sel == CLKOUT_HIGH_BAND),
      .clk_o(div_clk)
   );

   // Clock output mux
   always_comb begin
      case (clk_sel)
         CLKOUT_BUFFERED: clock_output_pin_o = sys_clk_i;
         CLKOUT_OFF: clock_output_pin_o = 1'b0;
         default: clock_output_pin_o = div_clk;
      endcase
   end

   // Serial port direction: slave unless standalone master strap
   always_comb begin
      frame_clock_pin_oe_o = (st_q.mode == MODE_STANDALONE) && !standalone_slave_i;
      bit_clock_pin_oe_o = frame_clock_pin_oe_o;
   end
   assign frame_clock_pin_o = st_q.fclk;
   assign bit_clock_pin_o = st_q.bclk;

   // Bus answer
   assign avs_waitrequest_o = req & ~st_q.ack;
   assign avs_readdata_o = st_q.rdata;
   assign avs_response_o = st_q.resp;

   // Configuration outputs
   assign osr_o = st_q.osr;
   assign low_latency_o = (band == FS_BAND_192_LL);
   assign mclk_ratio_shift_o = (band == FS_BAND_48) ? 3'h0 :
                               (band == FS_BAND_96) ? 3'h1 : 3'h2;
   assign tdm_mode_o = st_q.conv_ctrl[TDM_BIT];
   assign data_lines_used_o = st_q.conv_ctrl[TDM_BIT] ? 4'h1 : 4'h6;
   assign atten_o = st_q.atten;
   assign power_level_o = st_q.plevel;
   assign common_mode_ref_en_o = ~st_q.clk_ctrl_one[CM_OFF_BIT];
endmodule // dcc_top

//--- testbench/dac_channel_and_clock_output_config_bench.sv
// Purpose: Register-level bench for dcc_top
// Assumes: Avalon-MM answers within twenty cycles
// Notes: The audio source runs only while the device is slave
`timescale 1ns/100ps
module dac_channel_and_clock_output_config_bench
   import dcc_pkg::*;
;
   logic sys_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, run, prev;
   logic standalone_select_i, standalone_slave_i, standalone_tdm_i, low_latency_o;
   logic frame_clock_pin_i, frame_clock_pin_o, frame_clock_pin_oe_o, src_fc, src_bc;
   logic bit_clock_pin_i, bit_clock_pin_o, bit_clock_pin_oe_o, clock_output_pin_o;
   logic tdm_mode_o, common_mode_ref_en_o;
   logic [7:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rdv;
   logic [3:0] avs_byteenable_i, data_lines_used_o;
   logic [1:0] avs_response_o, rsp;
   logic [8:0] osr_o;
   logic [2:0] mclk_ratio_shift_o;
   logic [NUM_CHAN*8-1:0] atten_o;
   logic [NUM_CHAN*2-1:0] power_level_o;
   logic [7:0] pv [3] = '{8'h1b, 8'he4, 8'h1b};
   int sels [3] = '{0, 1, 3};
   int divs [3] = '{3, 2, 0};
   int fails = 0, check_count = 0, e, x;
   // Each clock pin follows the device while it drives, else the source
   assign frame_clock_pin_i = frame_clock_pin_oe_o ? frame_clock_pin_o : src_fc;
   assign bit_clock_pin_i = bit_clock_pin_oe_o ? bit_clock_pin_o : src_bc;
   dcc_top #(.MCLK_KHZ(12288)) dut_u (.*);
   dcc_audio_src src_u (.sys_clk_i, .rst_n_i, .run_i(run), .frame_clock_o(src_fc),
      .bit_clock_o(src_bc));
   // Master clock at 125 MHz
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Print counts and verdict, then stop
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One bus cycle, held until waitrequest is sampled low at a rising edge
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] b);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= {24'h000000, d};
      avs_byteenable_i <= b;
      @(posedge sys_clk_i);
      while (avs_waitrequest_o !== 1'b0 && n < 20) begin
         @(posedge sys_clk_i);
         n++;
      end
      if (n == 20) begin
         fails++;
         report_and_stop();
      end
      rdv = avs_readdata_o;
      rsp = avs_response_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(negedge sys_clk_i);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      access(1'b1, a, d, 4'h1);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      access(1'b0, a, 8'h00, 4'hf);
      check(rdv, exp);
   endtask
   // Main sequence
   initial begin
      rst_n_i = 1'b0;
      {avs_read_i, avs_write_i, standalone_select_i, standalone_tdm_i, run} = 5'h00;
      standalone_slave_i = 1'b1;
      avs_address_i = 8'h00;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'h0;
      repeat (8) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      run <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rchk(ADDR_CLK_CTRL_ONE, 32'h20);
      rchk(ADDR_STATUS, 32'h401);
      check(32'(common_mode_ref_en_o), 32'h1);
      @(posedge sys_clk_i);
      #2 check(32'(clock_output_pin_o), 32'h1);
      @(negedge sys_clk_i);
      #2 check(32'(clock_output_pin_o), 32'h0);
      rchk(8'h5c, 32'h0);
      check(32'(rsp), 32'h2);
      access(1'b1, ADDR_CLK_CTRL_ONE, 8'h31, 4'he);
      rchk(ADDR_CLK_CTRL_ONE, 32'h20);
      $display("test reset done");
      for (int f = 0; f < 4; f++) begin
         wreg(ADDR_CONV_CTRL_FIRST, 8'(f << FS_LSB) | 8'((f & 1) << TDM_BIT));
         check(32'(osr_o), f == 0 ? 32'd256 : f == 1 ? 32'd128 : 32'd64);
         check(32'(mclk_ratio_shift_o), f > 1 ? 32'd2 : 32'(f));
         check(32'(low_latency_o), 32'(f == 3));
         check(32'(data_lines_used_o), (f & 1) ? 32'd1 : 32'd6);
      end
      $display("test bands done");
      for (int n = 0; n < NUM_CHAN; n++) wreg(ADDR_ATTEN_BASE + 8'(4 * n), 8'hff - 8'(n));
      for (int n = 0; n < NUM_CHAN; n++) begin
         rchk(ADDR_ATTEN_BASE + 8'(4 * n), 32'(8'hff - 8'(n)));
         check(32'(atten_o[8*n +: 8]), 32'(8'hff - 8'(n)));
      end
      $display("test attenuation done");
      for (int r = 0; r < 3; r++) wreg(ADDR_POWER_BASE + 8'(4 * r), pv[r]);
      for (int g = 3; g >= 0; g--) begin
         wreg(ADDR_CLK_CTRL_ONE, 8'(g << GLOBAL_PWR_LSB) | 8'h20);
         for (int n = 0; n < NUM_CHAN; n++) begin
            e = g != 0 ? g : int'(pv[n/4][6-2*(n%4) +: 2]);
            check(32'(power_level_o[2*n +: 2]), 32'(e));
         end
      end
      wreg(ADDR_CLK_CTRL_ONE, 8'h21);
      check(32'(common_mode_ref_en_o), 32'h0);
      for (int i = 0; i < 3; i++) begin
         wreg(ADDR_CLK_CTRL_ONE, 8'(sels[i] << CLKOUT_SEL_LSB));
         if (divs[i] != 0) rchk(ADDR_CLK_DIV, 32'(divs[i]));
         x = divs[i] != 0 ? 120 / divs[i] : 0;
         e = 0;
         prev = clock_output_pin_o;
         repeat (120) begin
            @(negedge sys_clk_i);
            if (clock_output_pin_o && !prev) e++;
            prev = clock_output_pin_o;
         end
         check(32'(e >= x - 1 && e <= x + 1), 32'h1);
      end
      $display("test power and clock output done");
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      run <= 1'b0;
      {standalone_select_i, standalone_tdm_i, standalone_slave_i} <= 3'b110;
      repeat (8) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      wreg(ADDR_CLK_CTRL_ONE, 8'h31);
      rchk(ADDR_CLK_CTRL_ONE, 32'h20);
      rchk(ADDR_STATUS, 32'h403);
      check(32'(tdm_mode_o), 32'h1);
      check(32'(frame_clock_pin_oe_o & bit_clock_pin_oe_o), 32'h1);
      $display("test standalone done");
      report_and_stop();
   end
endmodule // dac_channel_and_clock_output_config_bench

//--- testbench/dcc_audio_src.sv
// Purpose: Audio processor model supplying frame and bit clocks
// Assumes: The bench clock stands for the shared master clock
// Notes: Both clocks stand low while run_i is low
`timescale 1ns/100ps
module dcc_audio_src (
   // Clock and control
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   // Serial clocks
   output logic frame_clock_o,
   output logic bit_clock_o
);
   logic [7:0] cnt_q;
   // One counter feeds both clocks so they stay coherent with the master
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) cnt_q <= 8'h00;
      else cnt_q <= run_i ? cnt_q + 8'h01 : 8'h00;
   end
   // Bit clock at a quarter, frame clock at 1/256 of the master clock
   assign bit_clock_o = run_i & cnt_q[1];
   assign frame_clock_o = run_i & cnt_q[7];
endmodule // dcc_audio_src

//--- testbench/dcc_monitor.sv
// Purpose: Port-level checks of the converter configuration block
// Assumes: A write decodes on the edge with write and waitrequest both high
// Notes: Shadows clock control one; mode is taken at the first edge after reset
`timescale 1ns/100ps
module dcc_monitor
   import dcc_pkg::*;
(
   // Clock, reset, bus and strap
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire logic standalone_select_i,
   // Configuration outputs
   input wire logic frame_clock_pin_oe_o,
   input wire logic bit_clock_pin_oe_o,
   input wire logic clock_output_pin_o,
   input wire logic [8:0] osr_o,
   input wire logic low_latency_o,
   input wire logic [2:0] mclk_ratio_shift_o,
   input wire logic tdm_mode_o,
   input wire logic [3:0] data_lines_used_o,
   input wire logic [NUM_CHAN*2-1:0] power_level_o,
   input wire logic common_mode_ref_en_o
);
   logic seen_q, sa_q, wr;
   logic [7:0] cc1_q;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // A write counts only in program mode with byte lane zero on
   assign wr = avs_write_i && avs_waitrequest_o && avs_byteenable_i[0] && seen_q && !sa_q;
   // Mode capture and clock control one shadow
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seen_q <= 1'b0;
         sa_q <= 1'b0;
         cc1_q <= RST_CLK_CTRL_ONE;
      end else begin
         seen_q <= 1'b1;
         if (!seen_q) begin
            sa_q <= standalone_select_i;
         end
         if (wr && avs_address_i == ADDR_CLK_CTRL_ONE) begin
            cc1_q <= avs_writedata_i[7:0];
         end
      end
   end
   // Ratio decode is combinational, osr is registered one cycle behind it
   property p_band_ratio; osr_o == (OSR_48 >> $past(mclk_ratio_shift_o)); endproperty
   a_band_ratio: assert property (p_band_ratio) else $error("osr vs ratio");
   // Low latency keeps the quarter ratio; registered osr shows the top band a cycle later
   property p_low_lat;
      low_latency_o |-> mclk_ratio_shift_o == 3'd2 ##1 osr_o == OSR_192;
   endproperty
   a_low_lat: assert property (p_low_lat) else $error("low latency band");
   property p_stereo; !tdm_mode_o |-> data_lines_used_o == 4'd6; endproperty
   a_stereo: assert property (p_stereo) else $error("stereo lines");
   property p_tdm; tdm_mode_o |-> data_lines_used_o == 4'd1; endproperty
   a_tdm: assert property (p_tdm) else $error("tdm line");
   property p_global; cc1_q[7:6] != PWR_BEST |=> power_level_o == {NUM_CHAN{$past(cc1_q[7:6])}};
   endproperty
   a_global: assert property (p_global) else $error("global power");
   property p_slave; seen_q && !sa_q |-> !frame_clock_pin_oe_o && !bit_clock_pin_oe_o; endproperty
   a_slave: assert property (p_slave) else $error("clock pins driven");
   property p_sa_start; seen_q && sa_q |-> common_mode_ref_en_o && osr_o == OSR_48; endproperty
   a_sa_start: assert property (p_sa_start) else $error("standalone defaults");
   property p_clk_off; cc1_q[5:4] == CLKOUT_OFF |-> !clock_output_pin_o; endproperty
   a_clk_off: assert property (p_clk_off) else $error("clock out not off");
   property p_cm_ref; common_mode_ref_en_o == !cc1_q[CM_OFF_BIT]; endproperty
   a_cm_ref: assert property (p_cm_ref) else $error("reference enable");
   property p_low_div;
      $past(cc1_q[5:4]) == CLKOUT_LOW_BAND && cc1_q[5:4] == CLKOUT_LOW_BAND
         && $rose(clock_output_pin_o) |-> ##[1:2] !clock_output_pin_o;
   endproperty
   a_low_div: assert property (p_low_div) else $error("divided high too long");
   c_low_lat: cover property (low_latency_o);
   c_standalone: cover property (seen_q && sa_q);
   c_lowest: cover property (cc1_q[7:6] == PWR_LOWEST);
endmodule // dcc_monitor
bind dcc_top dcc_monitor mon_u (.*);
